// ==== core/irmr_pkg.sv ====
// Constants, types and helper functions of the infrared Manchester receiver
//
// Notes on behaviour
// R1: Sample the remote input at timing 1 and timing 3, each field plus one periods.
// R2: At timing 2 classify the two sampled levels as data 0, data 1 or error.
// R3: End of reception when no edge comes and the counter reaches timing 4.
// R4: Every bit decision except the guide-less first bit uses exactly two samples of the remote input.
// R5: Software programs timing 1 below 2, below 3, below 4.
// R6: Software keeps timings and their spacings at least four judgement periods.
// R7: Guide-less format: first rising edge clears shift register and bit counter.
// R8: Guide-less format: first bit is 1 on a high sample, else a data error.
// R9: Shift each bit in; every 8 bits copy to data register, flag, clear.
// R10: Guide-less identification error sets data error and returns to idle.
// R11: An edge after timing 3 and before timing 4 restarts the bit cycle.
// R12: End sets end and hold flags; reading shift register clears hold, back to idle.
// R13: Guide format: valid guide clears counter, sets guide ok, clears shift and count.
// R14: Guide pulse is measured from one rising edge to the next.
// R15: Guide valid when width is at least low plus one, below high plus one.
// R16: Software keeps guide limits at least four periods and four apart.
// R17: After the guide, sample at timing 1 and need an edge before timing 3.
// R18: Guide format bit cycles sample at 1 and 3, test at 2, restart on edge.
// R19: Guide format data error sets the error flag and waits for a new guide.
// R20: After three normal cycles a valid bit clears counter and halves the clock.
// R21: Halved phase needs an edge between 1 and 3; next valid bit restores clock.
// R22: After the restored bit need an edge again, then normal cycles until end.
// R23: Received bits are counted so partial final bytes can be interpreted.
// R24: Judgement counter counts judgement periods from its last clear.
`default_nettype none

package irmr_pkg;

    localparam int JC_W = 6;
    localparam int FIELD_W = 5;
    localparam int DIV_W = 8;
    localparam int BCNT_W = 8;
    localparam logic [JC_W-1:0] TH_OFS = 6'h01;
    localparam logic [JC_W-1:0] JC_MAX = 6'h3F;
    localparam logic [1:0] NORM_CYCLES = 2'h3;
    localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMING = 8'h04;
    localparam logic [7:0] OFS_GUIDE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_SHIFT = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_JCOUNT = 8'h18;

    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FMT_BIT = 1;
    localparam int CTRL_MSB_BIT = 2;
    localparam int CTRL_DIV_LSB = 8;
    localparam int T1_LSB = 0;
    localparam int T2_LSB = 8;
    localparam int T3_LSB = 16;
    localparam int T4_LSB = 24;
    localparam int GL_LSB = 0;
    localparam int GH_LSB = 8;
    localparam int SHIFT_BCNT_LSB = 8;

    // Reset values
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
    localparam logic [FIELD_W-1:0] T1_RST = 5'h03;
    localparam logic [FIELD_W-1:0] T2_RST = 5'h07;
    localparam logic [FIELD_W-1:0] T3_RST = 5'h0B;
    localparam logic [FIELD_W-1:0] T4_RST = 5'h0F;
    localparam logic [FIELD_W-1:0] GL_RST = 5'h0F;
    localparam logic [FIELD_W-1:0] GH_RST = 5'h1F;

    typedef struct packed {
        logic [FIELD_W-1:0] t1;
        logic [FIELD_W-1:0] t2;
        logic [FIELD_W-1:0] t3;
        logic [FIELD_W-1:0] t4;
        logic [FIELD_W-1:0] gl;
        logic [FIELD_W-1:0] gh;
    } irmr_timing_t;

    typedef struct packed {
        logic guide_ok_flag;
        logic receive_hold_flag;
        logic receive_end_flag;
        logic data_error_flag;
        logic shift_full_flag;
    } irmr_flags_t;

    localparam irmr_flags_t FLAGS_W1C = 5'h17;

    typedef enum logic [2:0] {
        S_IDLE, S_GUIDE, S_EDGE13, S_T1, S_T2, S_T3, S_T4, S_HOLD
    } irmr_state_t;

    typedef enum logic [1:0] {STG_NORM, STG_HALF, STG_LATE} irmr_stage_t;

    // Threshold in judgement periods for a programmed field
    function automatic logic [JC_W-1:0] thr(input logic [FIELD_W-1:0] f);
        return JC_W'(f) + TH_OFS;
    endfunction : thr

    // Bit decision: {valid, value}
    function automatic logic [1:0] decode(input logic first, input logic prev,
                                          input logic cur);
        if (first) begin
            return {cur, 1'b1};
        end
        return {prev != cur, cur};
    endfunction : decode

    // Shift one bit into the receive byte
    function automatic logic [7:0] ins(input logic [7:0] sr, input logic b,
                                       input logic msb_first);
        return msb_first ? {sr[6:0], b} : {b, sr[7:1]};
    endfunction : ins

endpackage : irmr_pkg

`default_nettype wire

// ==== core/irmr_sync.sv ====
// Two-stage synchroniser with edge detection for the remote input
`default_nettype none

module irmr_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic din,
    output logic lvl,
    output logic rise,
    output logic any_edge
);
    import irmr_pkg::*;

    logic meta;
    logic stable;
    logic last;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            stable <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= din;
            stable <= meta;
            last <= stable;
        end
    end

    assign lvl = stable;
    assign rise = stable & ~last;
    assign any_edge = stable ^ last;

endmodule : irmr_sync

`default_nettype wire

// ==== core/irmr_jclk.sv ====
// Judgement clock tick generator with divide-by-two option
`default_nettype none

module irmr_jclk #(
    parameter int DW = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [DW-1:0] div,
    input wire logic halve,
    input wire logic restart,
    output logic tick
);
    import irmr_pkg::*;

    logic [DW:0] cnt;
    logic [DW:0] term;

    // Period is div+1 cycles, or twice that when halved
    assign term = halve ? {div, 1'b1} : {1'b0, div};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (restart) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt >= term) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : irmr_jclk

`default_nettype wire

// ==== core/irmr_receiver.sv ====
// Infrared Manchester receiver with AHB-Lite register slave
`default_nettype none

module irmr_receiver (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ir_in
);
    import irmr_pkg::*;

    // Configuration
    logic enable;
    logic fmt_guide;
    logic msb_first;
    logic [DIV_W-1:0] jdiv;
    irmr_timing_t tim;

    // Receive state
    irmr_state_t state, next_state;
    irmr_stage_t stage, next_stage;
    irmr_flags_t flags;
    logic [JC_W-1:0] judgement_counter;
    logic [7:0] rx_shift_reg;
    logic [7:0] rx_data_reg;
    logic [BCNT_W-1:0] rx_bit_counter;
    logic half, next_half;
    logic first, next_first;
    logic prev, next_prev;
    logic smp1, next_smp1;
    logic smp_done, next_smp_done;
    logic [1:0] norm, next_norm;

    // Control strobes
    logic jc_clr;
    logic frame_clr;
    logic bit_en;
    logic bit_val;
    logic set_err;
    logic set_end;
    logic set_gok;
    logic [1:0] dec;

    // Input and clock
    logic ir_lvl;
    logic ir_rise;
    logic ir_edge;
    logic jtick;

    // Bus
    logic acc;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_shift;
    logic [31:0] rmux;
    irmr_flags_t w1c;

    irmr_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(ir_in),
        .lvl(ir_lvl),
        .rise(ir_rise),
        .any_edge(ir_edge)
    );

    irmr_jclk #(.DW(DIV_W)) u_jclk (
        .sys_clk(sys_clk),
        .rst(rst),
        .div(jdiv),
        .halve(half),
        .restart(jc_clr),
        .tick(jtick)
    );

    // Judgement counter, saturating
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            judgement_counter <= '0;
        end else if (jc_clr) begin
            judgement_counter <= '0; // R24
        end else if (jtick && judgement_counter != JC_MAX) begin
            judgement_counter <= judgement_counter + 1'b1; // R24
        end
    end

    // Sequencing
    always_comb begin
        next_state = state;
        next_stage = stage;
        next_half = half;
        next_first = first;
        next_prev = prev;
        next_smp1 = smp1;
        next_smp_done = smp_done;
        next_norm = norm;
        jc_clr = 1'b0;
        frame_clr = 1'b0;
        bit_en = 1'b0;
        bit_val = 1'b0;
        set_err = 1'b0;
        set_end = 1'b0;
        set_gok = 1'b0;
        dec = decode(first, prev, smp1); // R4
        case (state)
            S_IDLE: begin
                next_half = 1'b0;
                next_stage = STG_NORM;
                next_norm = '0;
                if (enable && ir_rise) begin
                    jc_clr = 1'b1;
                    if (fmt_guide) begin
                        next_state = S_GUIDE; // R14
                    end else begin
                        frame_clr = 1'b1; // R7
                        next_first = 1'b1;
                        next_state = S_T1;
                    end
                end
            end
            S_GUIDE: begin
                if (ir_rise) begin
                    jc_clr = 1'b1; // R14
                    if (judgement_counter >= thr(tim.gl) &&
                        judgement_counter < thr(tim.gh)) begin // R15
                        set_gok = 1'b1; // R13
                        frame_clr = 1'b1; // R13
                        next_first = 1'b0;
                        next_smp_done = 1'b0;
                        next_state = S_EDGE13;
                    end
                end
            end
            S_EDGE13: begin
                if (!smp_done && judgement_counter >= thr(tim.t1)) begin
                    next_prev = ir_lvl; // R17
                    next_smp_done = 1'b1;
                end else if (smp_done && ir_edge && judgement_counter < thr(tim.t3)) begin
                    jc_clr = 1'b1; // R17
                    next_state = S_T1;
                end else if (judgement_counter >= thr(tim.t3)) begin
                    set_err = 1'b1; // R17
                    next_state = S_IDLE;
                end
            end
            S_T1: begin
                if (judgement_counter >= thr(tim.t1)) begin
                    next_smp1 = ir_lvl; // R1
                    next_state = S_T2;
                end
            end
            S_T2: begin
                if (judgement_counter >= thr(tim.t2)) begin
                    if (!dec[1]) begin
                        set_err = 1'b1; // R2 R8 R10 R19
                        next_state = S_IDLE;
                    end else begin
                        bit_en = 1'b1; // R2 R8
                        bit_val = dec[0];
                        next_first = 1'b0;
                        if (fmt_guide && stage == STG_NORM && norm == NORM_CYCLES) begin
                            jc_clr = 1'b1; // R20
                            next_half = 1'b1;
                            next_stage = STG_HALF;
                            next_smp_done = 1'b0;
                            next_state = S_EDGE13;
                        end else if (stage == STG_HALF) begin
                            jc_clr = 1'b1; // R21
                            next_half = 1'b0;
                            next_stage = STG_LATE; // R22
                            next_smp_done = 1'b0;
                            next_state = S_EDGE13;
                        end else begin
                            next_state = S_T3; // R18
                        end
                    end
                end
            end
            S_T3: begin
                if (judgement_counter >= thr(tim.t3)) begin
                    next_prev = ir_lvl; // R1
                    next_state = S_T4;
                end
            end
            S_T4: begin
                if (ir_edge && judgement_counter < thr(tim.t4)) begin
                    jc_clr = 1'b1; // R11 R18
                    if (norm != NORM_CYCLES) begin
                        next_norm = norm + 1'b1;
                    end
                    next_state = S_T1;
                end else if (judgement_counter >= thr(tim.t4)) begin
                    set_end = 1'b1; // R3
                    next_state = S_HOLD;
                end
            end
            S_HOLD: begin
                next_half = 1'b0;
                if (!flags.receive_hold_flag) begin
                    next_state = S_IDLE; // R12
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (!enable) begin
            next_state = S_IDLE;
            next_half = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            stage <= STG_NORM;
            half <= 1'b0;
            first <= 1'b0;
            prev <= 1'b0;
            smp1 <= 1'b0;
            smp_done <= 1'b0;
            norm <= '0;
        end else begin
            state <= next_state;
            stage <= next_stage;
            half <= next_half;
            first <= next_first;
            prev <= next_prev;
            smp1 <= next_smp1;
            smp_done <= next_smp_done;
            norm <= next_norm;
        end
    end

    // Shift register, bit counter and data register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_shift_reg <= '0;
            rx_data_reg <= '0;
            rx_bit_counter <= '0;
        end else if (frame_clr) begin
            rx_shift_reg <= '0; // R7 R13
            rx_bit_counter <= '0;
        end else if (bit_en) begin
            rx_bit_counter <= rx_bit_counter + 1'b1; // R23
            if (rx_bit_counter[2:0] == LAST_BIT_OF_BYTE) begin
                rx_data_reg <= ins(rx_shift_reg, bit_val, msb_first); // R9
                rx_shift_reg <= '0;
            end else begin
                rx_shift_reg <= ins(rx_shift_reg, bit_val, msb_first); // R9
            end
        end
    end

    // Status flags, set wins over clear
    assign w1c = (wr_pend && wr_addr == OFS_STATUS) ? (hwdata[4:0] & FLAGS_W1C) : '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags.shift_full_flag <= (flags.shift_full_flag & ~w1c.shift_full_flag) |
                (bit_en && rx_bit_counter[2:0] == LAST_BIT_OF_BYTE); // R9
            flags.data_error_flag <= (flags.data_error_flag & ~w1c.data_error_flag) | set_err;
            flags.receive_end_flag <= (flags.receive_end_flag & ~w1c.receive_end_flag) |
                set_end; // R12
            flags.receive_hold_flag <= (flags.receive_hold_flag & ~rd_shift) | set_end; // R12
            flags.guide_ok_flag <= (flags.guide_ok_flag & ~w1c.guide_ok_flag) | set_gok;
        end
    end

    // Bus slave: zero wait states, read data registered at address phase
    assign acc = hsel && htrans[1] && hready;
    assign rd_shift = acc && !hwrite && haddr[7:0] == OFS_SHIFT;

    always_comb begin
        case (haddr[7:0])
            OFS_CTRL: rmux = 32'({jdiv, 5'h00, msb_first, fmt_guide, enable});
            OFS_TIMING: rmux = {3'h0, tim.t4, 3'h0, tim.t3, 3'h0, tim.t2, 3'h0, tim.t1};
            OFS_GUIDE: rmux = 32'({3'h0, tim.gh, 3'h0, tim.gl});
            OFS_STATUS: rmux = 32'(flags);
            OFS_SHIFT: rmux = 32'({rx_bit_counter, rx_shift_reg});
            OFS_DATA: rmux = 32'(rx_data_reg);
            OFS_JCOUNT: rmux = 32'(judgement_counter);
            default: rmux = '0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= acc && hwrite;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (acc) begin
                wr_addr <= haddr[7:0];
            end
            if (acc && !hwrite) begin
                hrdata <= rmux;
            end
        end
    end

    // Configuration registers, written in the data phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable <= 1'b0;
            fmt_guide <= 1'b0;
            msb_first <= 1'b0;
            jdiv <= DIV_RST;
            tim <= {T1_RST, T2_RST, T3_RST, T4_RST, GL_RST, GH_RST};
        end else if (wr_pend) begin
            case (wr_addr)
                OFS_CTRL: begin
                    enable <= hwdata[CTRL_EN_BIT];
                    fmt_guide <= hwdata[CTRL_FMT_BIT];
                    msb_first <= hwdata[CTRL_MSB_BIT];
                    jdiv <= hwdata[CTRL_DIV_LSB +: DIV_W];
                end
                OFS_TIMING: begin
                    tim.t1 <= hwdata[T1_LSB +: FIELD_W];
                    tim.t2 <= hwdata[T2_LSB +: FIELD_W];
                    tim.t3 <= hwdata[T3_LSB +: FIELD_W];
                    tim.t4 <= hwdata[T4_LSB +: FIELD_W];
                end
                OFS_GUIDE: begin
                    tim.gl <= hwdata[GL_LSB +: FIELD_W];
                    tim.gh <= hwdata[GH_LSB +: FIELD_W];
                end
                default: begin
                end
            endcase
        end
    end

endmodule : irmr_receiver

`default_nettype wire

// ==== sim/irmr_receiver_monitor.sv ====
// Bus-side assertions for the infrared Manchester receiver
`default_nettype none

module irmr_receiver_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ir_in
);
    import irmr_pkg::*;

    logic acc;
    logic dp_rd;
    logic [7:0] dp_a;

    assign acc = hsel && htrans[1] && hready && !hwrite;

    // Read data phase tracking
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dp_rd <= 1'b0;
            dp_a <= 8'h00;
        end else begin
            dp_rd <= acc;
            dp_a <= haddr[7:0];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_rdata_hold: assert property (!acc |=> $stable(hrdata))
        else $error("hrdata changed without a read");
    chk_unmapped_zero: assert property (dp_rd && dp_a >= 8'h1C |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_width: assert property (dp_rd && dp_a == OFS_STATUS |-> hrdata[31:5] == 27'h0)
        else $error("status upper bits set");
    chk_shift_width: assert property (dp_rd && dp_a == OFS_SHIFT |-> hrdata[31:16] == 16'h0)
        else $error("shift upper bits set");
    chk_data_width: assert property (dp_rd && dp_a == OFS_DATA |-> hrdata[31:8] == 24'h0)
        else $error("data upper bits set");
    chk_jcount_range: assert property (dp_rd && dp_a == OFS_JCOUNT |-> hrdata[31:6] == 26'h0)
        else $error("judgement count too wide");

    cover property (acc && haddr[7:0] == OFS_SHIFT);
    cover property (dp_rd && dp_a == OFS_STATUS && hrdata[1]);
    cover property (dp_rd && dp_a == OFS_STATUS && hrdata[4]);

endmodule : irmr_receiver_monitor

bind irmr_receiver irmr_receiver_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ir_in(ir_in));

`default_nettype wire

// ==== sim/irmr_ir_tx.sv ====
// Infrared transmitter model sending Manchester frames and guide pulses
`default_nettype none

module irmr_ir_tx (
    input wire logic sys_clk,
    output logic ir_in
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 30;

    initial ir_in = 1'b0;

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold

    // Bit 1 rises mid-bit; bit dbl lasts twice as long; at bit err the mid edge is undone
    task automatic send(input logic [15:0] v, input int n, input int err, input int dbl);
        for (int i = n - 1; i >= 0; i--) begin
            ir_in <= !v[i];
            hold(n - 1 - i == dbl ? 2 * HALF : HALF);
            ir_in <= v[i];
            if (n - 1 - i == err) begin
                hold(4);
                ir_in <= !v[i];
                hold(60);
                ir_in <= 1'b0;
                return;
            end
            hold(n - 1 - i == dbl ? 2 * HALF : HALF);
        end
        hold(100);
        ir_in <= 1'b0;
        hold(10);
    endtask : send

    // Guide width runs from one rising edge to the next
    task automatic guide(input int w);
        ir_in <= 1'b1;
        hold(8);
        ir_in <= 1'b0;
        hold(w - 8);
        ir_in <= 1'b1;
        hold(200);
        ir_in <= 1'b0;
        hold(10);
    endtask : guide

    // Guide pulse, then a frame whose fifth bit spans the halved judgement clock
    task automatic gsend(input int w, input logic [15:0] v, input int n);
        ir_in <= 1'b1;
        hold(8);
        ir_in <= 1'b0;
        hold(w - 8);
        send(v, n, 99, 4);
    endtask : gsend

endmodule : irmr_ir_tx

`default_nettype wire

// ==== sim/irmr_receiver_tb.sv ====
// Self-checking bench for the infrared Manchester receiver
`default_nettype none

module irmr_receiver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irmr_pkg::*;

    logic sys_clk = 1'b0;
    logic rst, hsel, hwrite, rd_dp, hreadyout, hresp, ir_in;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [31:0] seed = 32'h6849DC91;
    logic [39:0] exq[$];
    logic [7:0] v8, r8;
    logic [10:0] v11;
    logic [11:0] v12;
    int miscompares = 0;
    int tests_run = 0;
    int gw[4] = '{66, 96, 140, 60};
    logic [31:0] gexp[4] = '{32'h12, 32'h12, 32'h0, 32'h0};

    irmr_receiver dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ir_in(ir_in));
    irmr_ir_tx tx (.sys_clk(sys_clk), .ir_in(ir_in));

    initial forever #12.5 sys_clk = !sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [7:0] a, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] reg %h expected %h seen %h", a, exp, seen);
        end
    endtask : check

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask : wait_ready

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        wait_ready();
        rd_dp <= 1'b0;
    endtask : ahb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exq.push_back({a, exp});
        ahb(1'b0, a, 32'h0);
    endtask : rd

    // Read results compared as the data phase completes
    always @(posedge sys_clk) begin
        if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
            check(exq[0][39:32], hrdata, exq[0][31:0]);
            exq.delete(0);
        end
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_dp = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_TIMING, 32'h0F0B0703);
        rd(OFS_GUIDE, 32'h00001F0F);
        rd(OFS_STATUS, 32'h0);
        rd(8'h1C, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'hFFFF0301);
        rd(OFS_CTRL, 32'h00000301);
        $display("test registers done");
        seed = lfsr(seed);
        v8 = seed[7:0] | 8'h80;
        r8 = {<<{v8}};
        tx.send({8'h0, v8}, 8, 99, 99);
        rd(OFS_STATUS, 32'h0D);
        rd(OFS_DATA, {24'h0, r8});
        rd(OFS_SHIFT, 32'h0800);
        rd(OFS_STATUS, 32'h05);
        ahb(1'b1, OFS_STATUS, 32'h1F);
        rd(OFS_STATUS, 32'h0);
        $display("test byte lsb done");
        ahb(1'b1, OFS_CTRL, 32'h305);
        seed = lfsr(seed);
        v11 = seed[10:0] | 11'h400;
        tx.send({5'h0, v11}, 11, 99, 99);
        rd(OFS_STATUS, 32'h0D);
        rd(OFS_DATA, {24'h0, v11[10:3]});
        rd(OFS_SHIFT, {16'h0, 8'h0B, 5'h0, v11[2:0]});
        ahb(1'b1, OFS_STATUS, 32'h1F);
        $display("test partial msb done");
        for (int e = 0; e < 8; e += 4) begin
            seed = lfsr(seed);
            tx.send({8'h0, seed[7:0] | 8'h80}, 8, e, 99);
            rd(OFS_STATUS, 32'h02);
            ahb(1'b1, OFS_STATUS, 32'h1F);
        end
        $display("test errors done");
        ahb(1'b1, OFS_CTRL, 32'h303);
        for (int g = 0; g < 4; g++) begin
            tx.guide(gw[g]);
            rd(OFS_STATUS, gexp[g]);
            ahb(1'b1, OFS_STATUS, 32'h1F);
        end
        $display("test guide done");
        seed = lfsr(seed);
        v12 = seed[11:0] & 12'h7FF;
        r8 = {<<{v12[11:4]}};
        tx.gsend(100, {4'h0, v12}, 12);
        rd(OFS_STATUS, 32'h1D);
        rd(OFS_DATA, {24'h0, r8});
        rd(OFS_SHIFT, {16'h0, 8'h0C, v12[0], v12[1], v12[2], v12[3], 4'h0});
        tx.hold(300);
        rd(OFS_JCOUNT, 32'h3F);
        $display("test guide frame done");
        report_and_stop();
    end

endmodule : irmr_receiver_tb

`default_nettype wire
